/* verilog/flrc_pkg.sv */
// flrc_pkg: offsets, field positions and reset values of the loop ratio registers
// assumes a 16-bit register word addressed by register index
package flrc_pkg;
  localparam int unsigned        FLRC_AW            = 16;
  localparam int unsigned        FLRC_DW            = 16;
  localparam logic [15:0]        FLRC_OFS_ENABLE    = 16'h0171;
  localparam logic [15:0]        FLRC_OFS_INTEGER   = 16'h0172;
  localparam logic [15:0]        FLRC_OFS_NUMER     = 16'h0173;
  localparam logic [15:0]        FLRC_OFS_DENOM     = 16'h0174;
  localparam int unsigned        FLRC_ENA_BIT       = 0;
  localparam int unsigned        FLRC_UPD_BIT       = 15;
  localparam int unsigned        FLRC_INT_W         = 10;
  localparam logic [9:0]         FLRC_INT_RST       = 10'h008;
  localparam logic [15:0]        FLRC_NUMER_RST     = 16'h0018;
  localparam logic [15:0]        FLRC_DENOM_RST     = 16'h007d;
  localparam logic               FLRC_ENA_RST       = 1'b0;
endpackage

/* verilog/flrc_field.sv */
// flrc_field: one ratio field with a staged copy and an applied copy
// assumes clk_sys_i domain; write and apply strobes are single-cycle
`timescale 1ns/100ps
module flrc_field #(
  parameter int unsigned       W   = 16,
  parameter logic [W-1:0]      RST = '0
) (
  input  wire logic            clk_sys_i,
  input  wire logic            sys_rst_i,
  input  wire logic            ce_i,
  input  wire logic            wr_i,
  input  wire logic [W-1:0]    wdata_i,
  input  wire logic            direct_i,
  input  wire logic            apply_i,
  output logic      [W-1:0]    staged_o,
  output logic      [W-1:0]    active_o
);
  typedef struct packed {
    logic [W-1:0] staged;
    logic [W-1:0] active;
  } flrc_fld_s;

  flrc_fld_s st_reg;
  flrc_fld_s st_next;

  always_comb begin
    st_next = st_reg;
    if (wr_i) begin
      st_next.staged = wdata_i;
    end
    // a value written together with the strobe is applied with it
    if (wr_i && (direct_i || apply_i)) begin
      st_next.active = wdata_i; // RQ2 RQ3
    end else if (apply_i) begin
      st_next.active = st_reg.staged; // RQ1
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_reg <= '{staged: RST, active: RST};
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign staged_o = st_reg.staged;
  assign active_o = st_reg.active;
endmodule

/* verilog/flrc_regs.sv */
// flrc_regs: enable and ratio registers of the fractional frequency-locked loop
// assumes a synchronous register port on clk_sys_i, one access per cycle
// Functional notes
// RQ1 - While enabled, integer and numerator writes are held until an update strobe applies both.
// RQ2 - While disabled, integer and numerator writes go straight to the loop.
// RQ3 - The update strobe is bit 15 of the integer register and acts only while enabled.
// RQ4 - Software sets the enable bit last, after all other settings.
// RQ5 - The integer multiplier is bits 9:0, unsigned, reset 008h.
// RQ6 - The numerator is bits 15:0 of its register, unsigned, reset 0018h.
// RQ7 - The denominator is bits 15:0 of its register, unsigned, reset 007dh.
// RQ8 - Software picks the sync input ratio code from the sync frequency band.
// RQ9 - Software picks sync gain and bandwidth select from the sync frequency band.
// RQ10 - Software derives the sync integer and fraction from operating and sync frequency.
// RQ11 - Software reduces numerator and denominator by their greatest common divisor.
// RQ12 - In fractional operation numerator and denominator are co-prime.
// RQ13 - Numerator is always below denominator.
// RQ14 - Software sets the sync enable bit last in its sequence.
// RQ15 - The update strobe reads zero and does nothing while disabled.
`timescale 1ns/100ps
module flrc_regs
(
  input  wire logic                         clk_sys_i,
  input  wire logic                         sys_rst_i,
  input  wire logic                         ce_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  input  wire logic [flrc_pkg::FLRC_AW-1:0] reg_addr_i,
  input  wire logic [flrc_pkg::FLRC_DW-1:0] reg_wdata_i,
  output logic      [flrc_pkg::FLRC_DW-1:0] reg_rdata_o,
  output logic                              loop_enable_o,
  output logic      [9:0]                   integer_multiplier_o,
  output logic      [15:0]                  fraction_numerator_o,
  output logic      [15:0]                  fraction_denominator_o
);
  import flrc_pkg::*;

  typedef struct packed {
    logic        ena;
    logic [15:0] denom;
    logic [15:0] rdata;
  } flrc_state_s;

  flrc_state_s st_reg;
  flrc_state_s st_next;

  logic        wr_ena;
  logic        wr_int;
  logic        wr_num;
  logic        wr_den;
  logic        apply;
  logic [9:0]  int_staged;
  logic [9:0]  int_active;
  logic [15:0] num_staged;
  logic [15:0] num_active;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  assign wr_ena = reg_wr_i && (reg_addr_i == FLRC_OFS_ENABLE);
  assign wr_int = reg_wr_i && (reg_addr_i == FLRC_OFS_INTEGER);
  assign wr_num = reg_wr_i && (reg_addr_i == FLRC_OFS_NUMER);
  assign wr_den = reg_wr_i && (reg_addr_i == FLRC_OFS_DENOM);
  // strobe acts only while running; ignored when disabled
  assign apply  = wr_int && reg_wdata_i[FLRC_UPD_BIT] && st_reg.ena; // RQ3 RQ15

  ////////////////////////////////////////////////////////////////////////////
  // staged ratio fields

  flrc_field #(
    .W   (FLRC_INT_W),
    .RST (FLRC_INT_RST)
  ) u_int (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .wr_i      (wr_int),
    .wdata_i   (reg_wdata_i[FLRC_INT_W-1:0]), // RQ5
    .direct_i  (!st_reg.ena),
    .apply_i   (apply),
    .staged_o  (int_staged),
    .active_o  (int_active)
  );

  flrc_field #(
    .W   (16),
    .RST (FLRC_NUMER_RST)
  ) u_num (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .wr_i      (wr_num),
    .wdata_i   (reg_wdata_i), // RQ6
    .direct_i  (!st_reg.ena),
    .apply_i   (apply),
    .staged_o  (num_staged),
    .active_o  (num_active)
  );

  ////////////////////////////////////////////////////////////////////////////
  // enable, denominator and read path

  always_comb begin
    st_next = st_reg;
    if (wr_ena) begin
      st_next.ena = reg_wdata_i[FLRC_ENA_BIT];
    end
    if (wr_den) begin
      st_next.denom = reg_wdata_i; // RQ7
    end
    st_next.rdata = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        FLRC_OFS_ENABLE:  st_next.rdata = {15'h0000, st_reg.ena};
        FLRC_OFS_INTEGER: st_next.rdata = {6'h00, int_staged}; // RQ15
        FLRC_OFS_NUMER:   st_next.rdata = num_staged;
        FLRC_OFS_DENOM:   st_next.rdata = st_reg.denom;
        default:          st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_reg <= '{ena: FLRC_ENA_RST, denom: FLRC_DENOM_RST, rdata: 16'h0000};
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o            = st_reg.rdata;
  assign loop_enable_o          = st_reg.ena;
  assign integer_multiplier_o   = int_active;
  assign fraction_numerator_o   = num_active;
  assign fraction_denominator_o = st_reg.denom;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_hold_while_enabled;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ce_i && st_reg.ena && wr_num && !apply) |=> $stable(fraction_numerator_o);
  endproperty
  a_hold_while_enabled: assert property (p_hold_while_enabled) // RQ1
    else $error("numerator changed without update strobe");

  property p_apply_both;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ce_i && apply) |=> (integer_multiplier_o == $past(reg_wdata_i[9:0]))
                          && (fraction_numerator_o == $past(num_staged));
  endproperty
  a_apply_both: assert property (p_apply_both) // RQ3
    else $error("update strobe did not apply staged values");

  property p_direct_write;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ce_i && !st_reg.ena && wr_int) |=>
        (integer_multiplier_o == $past(reg_wdata_i[9:0]));
  endproperty
  a_direct_write: assert property (p_direct_write) // RQ2
    else $error("direct integer write not applied");

  property p_int_hold;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ce_i && st_reg.ena && !apply) |=> $stable(integer_multiplier_o);
  endproperty
  a_int_hold: assert property (p_int_hold) // RQ1
    else $error("integer changed while running without strobe");

  property p_denom_write;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ce_i && wr_den) |=> (fraction_denominator_o == $past(reg_wdata_i));
  endproperty
  a_denom_write: assert property (p_denom_write) // RQ7
    else $error("denominator write lost");

  property p_strobe_reads_zero;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ce_i && reg_rd_i && reg_addr_i == FLRC_OFS_INTEGER) |=> !reg_rdata_o[15];
  endproperty
  a_strobe_reads_zero: assert property (p_strobe_reads_zero) // RQ15
    else $error("update strobe read back as one");

  property p_num_readback;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ce_i && wr_num) ##1 (ce_i && reg_rd_i && reg_addr_i == FLRC_OFS_NUMER)
        |=> (reg_rdata_o == $past(reg_wdata_i, 2));
  endproperty
  a_num_readback: assert property (p_num_readback) // RQ6
    else $error("numerator readback wrong");

  property p_enable_follows;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ce_i && wr_ena) |=> (loop_enable_o == $past(reg_wdata_i[0]));
  endproperty
  a_enable_follows: assert property (p_enable_follows) // RQ2
    else $error("enable bit write lost");

  property p_direct_numer;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ce_i && !st_reg.ena && wr_num) |=> (fraction_numerator_o == $past(reg_wdata_i));
  endproperty
  a_direct_numer: assert property (p_direct_numer) // RQ2
    else $error("direct numerator write not applied");

  property p_strobe_ignored_off;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ce_i && !st_reg.ena && wr_int && reg_wdata_i[FLRC_UPD_BIT]) |=>
        ($stable(fraction_numerator_o) && !loop_enable_o);
  endproperty
  a_strobe_ignored_off: assert property (p_strobe_ignored_off) // RQ15
    else $error("update strobe acted while disabled");

  property p_int_readback;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ce_i && reg_rd_i && reg_addr_i == FLRC_OFS_INTEGER) |=> (reg_rdata_o[15:10] == 6'h00);
  endproperty
  a_int_readback: assert property (p_int_readback) // RQ5
    else $error("integer register upper bits read back nonzero");

  property p_reset_values;
    @(posedge clk_sys_i)
      sys_rst_i |=> (!loop_enable_o && (integer_multiplier_o == FLRC_INT_RST)
                     && (fraction_numerator_o == FLRC_NUMER_RST)
                     && (fraction_denominator_o == FLRC_DENOM_RST));
  endproperty
  a_reset_values: assert property (p_reset_values) // RQ5 RQ6 RQ7
    else $error("ratio outputs not at reset values");

  property p_enable_no_apply;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ce_i && wr_ena) |=> ($stable(integer_multiplier_o) && $stable(fraction_numerator_o));
  endproperty
  a_enable_no_apply: assert property (p_enable_no_apply) // RQ1
    else $error("enable write changed applied ratio");
endmodule

/* sim/test_flrc_regs.sv */
// test_flrc_regs: self-checking bench for the loop ratio register block
// assumes flrc_pkg and flrc_regs are compiled first; inputs change on the falling edge
`timescale 1ns/100ps
module test_flrc_regs;
  import flrc_pkg::*;
  logic        clk_sys_i   = 1'b0;
  logic        sys_rst_i   = 1'b1;
  logic        ce_i        = 1'b1;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic [15:0] reg_addr_i  = 16'h0000;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [15:0] reg_rdata_o;
  logic        loop_enable_o;
  logic [9:0]  int_o;
  logic [15:0] num_o;
  logic [15:0] den_o;
  int          n_mismatch  = 0;
  int          cmp_count   = 0;
  int unsigned cfg_g;
  int unsigned cfg_n;
  int unsigned cfg_t;
  int unsigned cfg_l;
  // 90.3168 MHz loop from 12 MHz; the 1 to 13.5 MHz band divides by 1, as for the sync input
  localparam int unsigned F_VCO = 90316800;
  localparam int unsigned F_REF = 12000000;
  localparam int unsigned RATIO = 1;

  always #50 clk_sys_i = ~clk_sys_i;

  flrc_regs dut_u (
    .clk_sys_i              (clk_sys_i),
    .sys_rst_i              (sys_rst_i),
    .ce_i                   (ce_i),
    .reg_wr_i               (reg_wr_i),
    .reg_rd_i               (reg_rd_i),
    .reg_addr_i             (reg_addr_i),
    .reg_wdata_i            (reg_wdata_i),
    .reg_rdata_o            (reg_rdata_o),
    .loop_enable_o          (loop_enable_o),
    .integer_multiplier_o   (int_o),
    .fraction_numerator_o   (num_o),
    .fraction_denominator_o (den_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    @(negedge clk_sys_i);
    reg_wr_i    = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(negedge clk_sys_i);
    reg_rd_i   = 1'b1;
    reg_addr_i = a;
    @(negedge clk_sys_i);
    reg_rd_i   = 1'b0;
    chk("rdata", exp, reg_rdata_o);
  endtask

  // write, then read the same index in the very next cycle
  task automatic wr_rd(input logic [15:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(negedge clk_sys_i);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    @(negedge clk_sys_i);
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b1;
    @(negedge clk_sys_i);
    reg_rd_i    = 1'b0;
    chk("rdata", exp, reg_rdata_o);
  endtask

  function automatic int unsigned gcd(input int unsigned a, input int unsigned b);
    int unsigned t;
    while (b != 0) begin
      t = a % b;
      a = b;
      b = t;
    end
    return a;
  endfunction

  // applied outputs: enable, integer, numerator, denominator
  task automatic outs(input logic e, input logic [9:0] n, input logic [15:0] t,
                      input logic [15:0] l);
    chk("enable", {15'h0000, e}, {15'h0000, loop_enable_o});
    chk("integer", {6'h00, n}, {6'h00, int_o});
    chk("numerator", t, num_o);
    chk("denominator", l, den_o);
  endtask

  task automatic complete_run;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(100 * 5000);
    n_mismatch++;
    complete_run();
  end

  initial begin
    repeat (6) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    cfg_n = F_VCO / (RATIO * F_REF);
    cfg_g = gcd(RATIO * F_REF, F_VCO);
    cfg_t = (F_VCO - cfg_n * RATIO * F_REF) / cfg_g;
    cfg_l = (RATIO * F_REF) / cfg_g;
    outs(1'b0, 10'h008, 16'h0018, 16'h007d);
    rd(16'h0171, 16'h0000);
    rd(16'h0172, 16'h0008);
    rd(16'h0173, 16'h0018);
    rd(16'h0174, 16'h007d);
    rd(16'h0175, 16'h0000);
    // disabled: direct writes, strobe bit ignored
    wr(16'h0172, 16'h83ff);
    outs(1'b0, 10'h3ff, 16'h0018, 16'h007d);
    rd(16'h0172, 16'h03ff);
    wr(16'h0173, 16'hffff);
    wr(16'h0174, 16'hfffe);
    outs(1'b0, 10'h3ff, 16'hffff, 16'hfffe);
    wr(16'h0175, 16'h1234);
    outs(1'b0, 10'h3ff, 16'hffff, 16'hfffe);
    // clock enable low freezes state and read data
    ce_i = 1'b0;
    wr(16'h0173, 16'h0001);
    rd(16'h0172, 16'h0000);
    ce_i = 1'b1;
    outs(1'b0, 10'h3ff, 16'hffff, 16'hfffe);
    // enable with upper bits set; only bit 0 stored
    wr(16'h0171, 16'hffff);
    rd(16'h0171, 16'h0001);
    // enabled: staged writes held until strobe
    wr(16'h0172, 16'h0055);
    wr_rd(16'h0173, 16'h0abc, 16'h0abc);
    outs(1'b1, 10'h3ff, 16'hffff, 16'hfffe);
    rd(16'h0172, 16'h0055);
    rd(16'h0173, 16'h0abc);
    wr(16'h0174, 16'h0100);
    outs(1'b1, 10'h3ff, 16'hffff, 16'h0100);
    wr(16'h0172, 16'h8000);
    outs(1'b1, 10'h000, 16'h0abc, 16'h0100);
    rd(16'h0172, 16'h0000);
    // numerator change then strobe with a new integer
    wr(16'h0173, 16'h0000);
    outs(1'b1, 10'h000, 16'h0abc, 16'h0100);
    wr(16'h0172, 16'h8200);
    outs(1'b1, 10'h200, 16'h0000, 16'h0100);
    // disable again: direct path returns
    wr(16'h0171, 16'h0000);
    wr(16'h0173, 16'h0077);
    outs(1'b0, 10'h200, 16'h0077, 16'h0100);
    // computed ratio written while disabled, enable as the last step
    wr(16'h0172, cfg_n[15:0]);
    wr(16'h0173, cfg_t[15:0]);
    wr(16'h0174, cfg_l[15:0]);
    outs(1'b0, cfg_n[9:0], cfg_t[15:0], cfg_l[15:0]);
    wr(16'h0171, 16'h0001);
    // sync enable index lies outside this block: set last, then ignored
    wr(16'h0181, 16'h0001);
    rd(16'h0181, 16'h0000);
    outs(1'b1, cfg_n[9:0], cfg_t[15:0], cfg_l[15:0]);
    // reset in mid-run restores defaults
    @(negedge clk_sys_i);
    sys_rst_i = 1'b1;
    @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    outs(1'b0, 10'h008, 16'h0018, 16'h007d);
    rd(16'h0171, 16'h0000);
    wr_rd(16'h0173, 16'h0042, 16'h0042);
    outs(1'b0, 10'h008, 16'h0042, 16'h007d);
    complete_run();
  end
endmodule
